// *** rtl/caf_map.svh ***
`ifndef CAF_MAP_SVH
`define CAF_MAP_SVH
// Register addresses on the serial register port
`define CAF_LIVE_ADDR 8'h82
`define CAF_LOSS_ADDR 8'h83
`define CAF_OFFS_ADDR 8'h84
// Live status field positions
`define CAF_LIVE_HOLD_BIT 6
`define CAF_LIVE_OFFS_LSB 1
`define CAF_LIVE_UNLOCK_BIT 0
// Signal loss flag field positions
`define CAF_LOSS_IN_LSB 1
`define CAF_LOSS_REF_BIT 0
// Offset and lock flag field positions
`define CAF_OFFS_IN_LSB 2
`define CAF_OFFS_UNLOCK_BIT 1
// Reset values
`define CAF_FLAGS_RST 10'h000
`define CAF_RDATA_RST 8'h00
// Rate band codes
`define CAF_RATE_MAX 3'h5
`endif

// *** rtl/caf_pkg.sv ***
`default_nettype none
package caf_pkg;
  typedef enum logic [1:0] {
    CAF_REG_LIVE = 2'b00,
    CAF_REG_LOSS = 2'b01,
    CAF_REG_OFFS = 2'b10,
    CAF_REG_NONE = 2'b11
  } caf_reg_t;
endpackage
`default_nettype wire

// *** rtl/caf_rate_chk.sv ***
`include "caf_map.svh"
`default_nettype none
// Gates an input's offset alarm by a legal rate band code
module caf_rate_chk (
  input wire logic [2:0] rate_in,
  input wire logic alarm_in,
  output logic alarm_out
);
  // Reserved codes cannot produce an offset alarm
  assign alarm_out = alarm_in & (rate_in <= `CAF_RATE_MAX);
endmodule
`default_nettype wire

// *** rtl/caf_sticky.sv ***
`default_nettype none
// One held alarm bit with mask and write-zero clear
module caf_sticky (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic en_in,
  input wire logic live_in,
  input wire logic clr_in,
  input wire logic mask_in,
  output logic flag_out,
  output logic req_out
);
  typedef struct packed {
    logic flag;
  } caf_st_t;
  caf_st_t st_r;
  caf_st_t st_nxt;

  // Set wins over clear; writing one is ignored
  always_comb begin
    st_nxt = st_r;
    if (en_in) begin
      if (live_in) begin
        st_nxt.flag = 1'b1;
      end else if (clr_in) begin
        st_nxt.flag = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign flag_out = st_r.flag;
  assign req_out = st_r.flag & ~mask_in;
endmodule
`default_nettype wire

// *** rtl/caf_top.sv ***
`include "caf_map.svh"
`default_nettype none
module caf_top
  import caf_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic hold_filter_valid_in,
  input wire logic [3:0] input_offset_live_in,
  input wire logic unlock_live_in,
  input wire logic [3:0] input_sigloss_live_in,
  input wire logic refin_sigloss_live_in,
  input wire logic [11:0] input_rate_band_sel_in,
  input wire logic [9:0] flag_mask_in,
  input wire logic int_pin_en_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic int_out
);
  typedef struct packed {
    logic [7:0] rdata;
    logic irq;
  } caf_top_st_t;
  caf_top_st_t st_r;
  caf_top_st_t st_nxt;

  logic [3:0] offs_q;
  logic [9:0] live_v;
  logic [9:0] clr_v;
  logic [9:0] flag_v;
  logic [9:0] req_v;
  logic [7:0] live_word;
  logic [7:0] loss_word;
  logic [7:0] offs_word;
  caf_reg_t wsel;
  caf_reg_t rsel;

  // Address decode shared by read and write paths
  function automatic caf_reg_t caf_dec(input logic [7:0] a);
    case (a)
      `CAF_LIVE_ADDR: caf_dec = CAF_REG_LIVE;
      `CAF_LOSS_ADDR: caf_dec = CAF_REG_LOSS;
      `CAF_OFFS_ADDR: caf_dec = CAF_REG_OFFS;
      default: caf_dec = CAF_REG_NONE;
    endcase
  endfunction

  assign wsel = caf_dec(reg_addr_in);
  assign rsel = caf_dec(reg_addr_in);

  // Offset alarms qualified by rate band
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_rate
      caf_rate_chk u_rate (
        .rate_in(input_rate_band_sel_in[gi*3 +: 3]),
        .alarm_in(input_offset_live_in[gi]),
        .alarm_out(offs_q[gi])
      );
    end
  endgenerate

  // Flag order: 0 ref loss, 1..4 input loss, 5 unlock, 6..9 offset
  assign live_v = {offs_q, unlock_live_in, input_sigloss_live_in,
                   refin_sigloss_live_in};

  // Clearing writes: zero in a flag position; reserved bits ignored
  always_comb begin
    clr_v = '0;
    if (reg_wr_in && wsel == CAF_REG_LOSS) begin
      clr_v[0] = ~reg_wdata_in[`CAF_LOSS_REF_BIT];
      clr_v[4:1] = ~reg_wdata_in[`CAF_LOSS_IN_LSB +: 4];
    end
    if (reg_wr_in && wsel == CAF_REG_OFFS) begin
      clr_v[5] = ~reg_wdata_in[`CAF_OFFS_UNLOCK_BIT];
      clr_v[9:6] = ~reg_wdata_in[`CAF_OFFS_IN_LSB +: 4];
    end
  end

  // One held flag per alarm source
  generate
    for (gi = 0; gi < 10; gi++) begin : g_flag
      caf_sticky u_flag (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .en_in(ce_in),
        .live_in(live_v[gi]),
        .clr_in(clr_v[gi]),
        .mask_in(flag_mask_in[gi]),
        .flag_out(flag_v[gi]),
        .req_out(req_v[gi])
      );
    end
  endgenerate

  // Register images, reserved bits zero
  always_comb begin
    live_word = 8'h00;
    live_word[`CAF_LIVE_HOLD_BIT] = hold_filter_valid_in;
    live_word[`CAF_LIVE_OFFS_LSB +: 4] = input_offset_live_in;
    live_word[`CAF_LIVE_UNLOCK_BIT] = unlock_live_in;
    loss_word = 8'h00;
    loss_word[`CAF_LOSS_IN_LSB +: 4] = flag_v[4:1];
    loss_word[`CAF_LOSS_REF_BIT] = flag_v[0];
    offs_word = 8'h00;
    offs_word[`CAF_OFFS_IN_LSB +: 4] = flag_v[9:6];
    offs_word[`CAF_OFFS_UNLOCK_BIT] = flag_v[5];
  end

  // Read data and interrupt registered
  always_comb begin
    st_nxt = st_r;
    if (ce_in) begin
      st_nxt.irq = int_pin_en_in & (|req_v);
      if (reg_rd_in) begin
        case (rsel)
          CAF_REG_LIVE: st_nxt.rdata = live_word;
          CAF_REG_LOSS: st_nxt.rdata = loss_word;
          CAF_REG_OFFS: st_nxt.rdata = offs_word;
          default: st_nxt.rdata = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= '{rdata: `CAF_RDATA_RST, irq: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_out = st_r.rdata;
  assign int_out = st_r.irq;

  // Alarm seen with clock enabled sets flag next cycle
  property p_loss_set;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && input_sigloss_live_in[0]) |=> flag_v[1];
  endproperty
  a_loss_set: assert property (p_loss_set)
    else $error("loss flag not set");

  property p_ref_set;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && refin_sigloss_live_in) |=> flag_v[0];
  endproperty
  a_ref_set: assert property (p_ref_set)
    else $error("ref flag not set");

  // Rate-qualified offset alarm sets its flag
  property p_offs_set;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && offs_q[1]) |=> flag_v[7];
  endproperty
  a_offs_set: assert property (p_offs_set)
    else $error("offset flag not set");

  property p_unlock_set;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && unlock_live_in) |=> flag_v[5];
  endproperty
  a_unlock_set: assert property (p_unlock_set)
    else $error("unlock flag");

  // Reserved rate code keeps a clear offset flag clear
  property p_rate_block;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && !flag_v[8] &&
        input_rate_band_sel_in[8:6] > `CAF_RATE_MAX) |=> !flag_v[8];
  endproperty
  a_rate_block: assert property (p_rate_block)
    else $error("offset flag set on reserved band");

  // Clearing write with the alarm quiet drops the flag
  sequence s_clear_req;
    ce_in && reg_wr_in && wsel == CAF_REG_OFFS &&
      !reg_wdata_in[`CAF_OFFS_UNLOCK_BIT] && !unlock_live_in;
  endsequence
  property p_clear;
    @(posedge clk_in) disable iff (!nrst_in)
      s_clear_req |=> !flag_v[5];
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared");

  sequence s_ref_clear_req;
    ce_in && reg_wr_in && wsel == CAF_REG_LOSS &&
      !reg_wdata_in[`CAF_LOSS_REF_BIT] && !refin_sigloss_live_in;
  endsequence
  property p_ref_clear;
    @(posedge clk_in) disable iff (!nrst_in)
      s_ref_clear_req |=> !flag_v[0];
  endproperty
  a_ref_clear: assert property (p_ref_clear)
    else $error("ref flag not cleared");

  // Live alarm beats a clearing write in the same cycle
  property p_set_wins;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && clr_v[4] && input_sigloss_live_in[3]) |=> flag_v[4];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("clear beat live alarm");

  property p_hold;
    @(posedge clk_in) disable iff (!nrst_in)
      (flag_v[9] && !(ce_in && clr_v[9])) |=> flag_v[9];
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped");

  // Writes to the live status register clear nothing
  property p_ro_write;
    @(posedge clk_in) disable iff (!nrst_in)
      (reg_wr_in && wsel == CAF_REG_LIVE) |-> clr_v == 10'h000;
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("live register write cleared a flag");

  // Interrupt follows unmasked flags one cycle later
  property p_irq;
    @(posedge clk_in) disable iff (!nrst_in)
      ce_in |=> int_out == $past(int_pin_en_in && (|req_v));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt wrong");

  property p_pin_off;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && !int_pin_en_in) |=> !int_out;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("irq with pin disabled");

  property p_mask;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && (&flag_mask_in)) |=> !int_out;
  endproperty
  a_mask: assert property (p_mask)
    else $error("masked irq seen");

  // Masked flag still latches its alarm
  property p_mask_latch;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && flag_mask_in[5] && unlock_live_in) |=> flag_v[5];
  endproperty
  a_mask_latch: assert property (p_mask_latch)
    else $error("masked flag did not latch");

  // Read data images and reserved bits
  property p_live_read;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && reg_rd_in && rsel == CAF_REG_LIVE) |=>
        reg_rdata_out == $past(live_word) && !reg_rdata_out[7];
  endproperty
  a_live_read: assert property (p_live_read)
    else $error("live read");

  property p_live_bits;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && reg_rd_in && rsel == CAF_REG_LIVE) |=>
        reg_rdata_out[4:1] == $past(input_offset_live_in) &&
        reg_rdata_out[0] == $past(unlock_live_in);
  endproperty
  a_live_bits: assert property (p_live_bits)
    else $error("live alarm bits wrong");

  property p_rsvd;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && reg_rd_in && rsel == CAF_REG_OFFS) |=>
        reg_rdata_out[7:6] == 2'h0 && !reg_rdata_out[0];
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved bits set");

  property p_loss_rsvd;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && reg_rd_in && rsel == CAF_REG_LOSS) |=>
        reg_rdata_out[7:5] == 3'h0;
  endproperty
  a_loss_rsvd: assert property (p_loss_rsvd)
    else $error("loss reserved bits set");

  property p_unmapped;
    @(posedge clk_in) disable iff (!nrst_in)
      (ce_in && reg_rd_in && rsel == CAF_REG_NONE) |=>
        reg_rdata_out == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  // Clock enable low freezes flags and outputs
  property p_freeze;
    @(posedge clk_in) disable iff (!nrst_in)
      !ce_in |=> $stable(flag_v) && $stable(reg_rdata_out) &&
        $stable(int_out);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while frozen");
endmodule
`default_nettype wire

// *** sim/caf_top_tb_top.sv ***
`default_nettype none
module caf_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, nrst_in = 0, ce_in = 1, hv = 0, unl = 0, rl = 0;
  logic ien = 0, wr = 0, rd = 0, irq;
  logic [3:0] offs = 0, los = 0;
  logic [11:0] rate = 0;
  logic [9:0] msk = 0;
  logic [7:0] addr = 0, wd = 0, rdat;
  int error_cnt = 0, n_checks = 0;
  caf_top u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
    .hold_filter_valid_in(hv), .input_offset_live_in(offs),
    .unlock_live_in(unl), .input_sigloss_live_in(los),
    .refin_sigloss_live_in(rl), .input_rate_band_sel_in(rate),
    .flag_mask_in(msk), .int_pin_en_in(ien), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wd),
    .reg_rdata_out(rdat), .int_out(irq));
  // 50 MHz clock
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Compare a register byte
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t byte %h want %h", $time, got, exp);
    end
  endtask
  // Compare the interrupt level
  task automatic chk1(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t irq %b want %b", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  // One-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  // Read strobe, then compare the registered answer
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    cyc(1);
    chk8(rdat, exp);
  endtask
  // Alarms high for two cycles, then quiet
  task automatic pulse(input logic [3:0] o, input logic [3:0] l,
                       input logic r, input logic u);
    @(posedge clk_in);
    offs <= o;
    los <= l;
    rl <= r;
    unl <= u;
    repeat (2) @(posedge clk_in);
    offs <= 4'h0;
    los <= 4'h0;
    rl <= 1'b0;
    unl <= 1'b0;
  endtask
  task automatic t_live();
    rd_chk(8'h83, 8'h00);
    @(posedge clk_in);
    hv <= 1'b1;
    offs <= 4'ha;
    unl <= 1'b1;
    rd_chk(8'h82, 8'h55);
    wr_reg(8'h82, 8'h00);
    rd_chk(8'h82, 8'h55);
    rd_chk(8'h85, 8'h00);
    rd_chk(8'h84, 8'h2a);
    @(posedge clk_in);
    hv <= 1'b0;
    offs <= 4'h0;
    unl <= 1'b0;
    rd_chk(8'h82, 8'h00);
    wr_reg(8'h84, 8'hff);
    rd_chk(8'h84, 8'h2a);
    wr_reg(8'h84, 8'h00);
    rd_chk(8'h84, 8'h00);
    $display("t_live done");
  endtask
  task automatic t_loss();
    pulse(4'h0, 4'h6, 1'b1, 1'b0);
    rd_chk(8'h83, 8'h0d);
    @(posedge clk_in);
    los <= 4'h8;
    wr_reg(8'h83, 8'h00);
    rd_chk(8'h83, 8'h10);
    @(posedge clk_in);
    los <= 4'h0;
    wr_reg(8'h83, 8'h00);
    rd_chk(8'h83, 8'h00);
    $display("t_loss done");
  endtask
  task automatic t_rate();
    @(posedge clk_in);
    rate <= {3'h7, 3'h6, 3'h5, 3'h0};
    pulse(4'hf, 4'h0, 1'b0, 1'b0);
    rd_chk(8'h84, 8'h0c);
    @(posedge clk_in);
    rate <= 12'h000;
    wr_reg(8'h84, 8'h00);
    $display("t_rate done");
  endtask
  task automatic t_int();
    @(posedge clk_in);
    ien <= 1'b1;
    pulse(4'h0, 4'h0, 1'b1, 1'b0);
    cyc(3);
    chk1(irq, 1'b1);
    @(posedge clk_in);
    msk <= 10'h001;
    cyc(3);
    chk1(irq, 1'b0);
    @(posedge clk_in);
    msk <= 10'h3fe;
    ien <= 1'b0;
    cyc(3);
    chk1(irq, 1'b0);
    @(posedge clk_in);
    ien <= 1'b1;
    cyc(3);
    chk1(irq, 1'b1);
    wr_reg(8'h83, 8'h00);
    cyc(3);
    chk1(irq, 1'b0);
    pulse(4'h0, 4'h0, 1'b0, 1'b1);
    rd_chk(8'h84, 8'h02);
    chk1(irq, 1'b0);
    $display("t_int done");
  endtask
  // Clock enable low: no latching, no read, no interrupt change
  task automatic t_freeze();
    @(posedge clk_in);
    ce_in <= 1'b0;
    rl <= 1'b1;
    msk <= 10'h000;
    cyc(3);
    chk1(irq, 1'b0);
    rd_chk(8'h83, 8'h02);
    @(posedge clk_in);
    rl <= 1'b0;
    ce_in <= 1'b1;
    rd_chk(8'h83, 8'h00);
    chk1(irq, 1'b1);
    wr_reg(8'h84, 8'h00);
    rd_chk(8'h84, 8'h00);
    chk1(irq, 1'b0);
    $display("t_freeze done");
  endtask
  // Full mask, then a mid-run reset clears flags and outputs
  task automatic t_reset();
    pulse(4'h0, 4'h1, 1'b0, 1'b0);
    rd_chk(8'h83, 8'h02);
    chk1(irq, 1'b1);
    @(posedge clk_in);
    msk <= 10'h3ff;
    cyc(3);
    chk1(irq, 1'b0);
    @(posedge clk_in);
    nrst_in <= 1'b0;
    cyc(2);
    chk1(irq, 1'b0);
    chk8(rdat, 8'h00);
    @(posedge clk_in);
    nrst_in <= 1'b1;
    rd_chk(8'h83, 8'h00);
    $display("t_reset done");
  endtask
  // Reset for 20 cycles, then the scenarios
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'b1;
    cyc(2);
    t_live();
    t_loss();
    t_rate();
    t_int();
    t_freeze();
    t_reset();
    give_verdict();
  end
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule
`default_nettype wire
